// ==== src/sap_adc_ctrl.sv ====
// Purpose: Control and parallel read-out of a four-channel 16-bit successive-approximation converter
// Assumes: sys_clk_i is the converter clock; host pins are asynchronous; sar_result_i is the finished SAR word
// Notes:   Hold and bus outputs are registered, so they trail the pins by the synchroniser delay
//          Busy stands for exactly eighteen divided ticks; the divider restarts with each conversion
//          In 8-bit mode the upper lines stay undriven and the low result byte cannot be read
//          ce_i low freezes every flop, synchronisers included
module sap_adc_ctrl
    import sap_pkg::*;
(
    input  wire logic                sys_clk_i,
    input  wire logic                rstn_i,
    input  wire logic                ce_i,
    input  wire sap_pins_t           pins_i,
    input  wire logic [RESULT_W-1:0] sar_result_i,
    output logic                     busy_o,
    output logic                     hold_mode_o,
    output logic [1:0]               channel_select_o,
    output logic [CHAN_N-1:0]        channel_enable_o,
    output logic [RESULT_W-1:0]      result_bus_o,
    output logic [RESULT_W-1:0]      result_bus_oe_o
);
    // Synchroniser and strobe edge detect
    sap_pins_t           pins_meta;
    sap_pins_t           pins_sync;
    sap_pins_t           next_pins_meta;
    sap_pins_t           next_pins_sync;
    logic                trig_prev;
    logic                next_trig_prev;
    logic                trig_fall;
    logic                trig_rise;

    // Conversion sequencer
    sap_state_t          state;
    sap_state_t          next_state;
    logic [4:0]          tick_cnt;
    logic [4:0]          next_tick_cnt;
    logic                last_tick;
    logic                div_tick;
    logic [RESULT_W-1:0] result;
    logic [RESULT_W-1:0] next_result;
    logic                next_busy;
    logic                next_hold;

    // Channel capture
    logic [1:0]          next_channel;
    logic [CHAN_N-1:0]   next_chan_en;

    // Read path
    logic                reading;
    sap_bus_t            next_bus;

    // Lane placement for the selected bus width
    function automatic sap_bus_t bus_word(input logic [RESULT_W-1:0] word, input logic byte_sel,
                                          input logic drive);
        sap_bus_t b;
        if (byte_sel) begin
            b.data = {BYTE_ZERO, word[RESULT_W-1:BYTE_W]};
            b.oe   = OE_LOW_BYTE;
        end else begin
            b.data = word;
            b.oe   = OE_FULL;
        end
        if (!drive) begin
            b.oe = OE_NONE;
        end
        return b;
    endfunction

    // Pins are asynchronous: two flops before any logic reads them
    always_comb begin
        next_pins_meta = pins_i;
        next_pins_sync = pins_meta;
        next_trig_prev = pins_sync.sample_hold_trigger_n;
    end

    // With ce_i low nothing moves, so no strobe edge is lost or seen twice
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            pins_meta <= PINS_IDLE;
            pins_sync <= PINS_IDLE;
            trig_prev <= 1'b1;
        end else if (ce_i) begin
            pins_meta <= next_pins_meta;
            pins_sync <= next_pins_sync;
            trig_prev <= next_trig_prev;
        end
    end

    // Previous strobe resets to its idle high level, so reset leaves no false edge
    assign trig_fall = trig_prev & ~pins_sync.sample_hold_trigger_n;
    assign trig_rise = ~trig_prev & pins_sync.sample_hold_trigger_n;

    // Divider phase restarts on the detect cycle so tick spacing is exact from the start
    sap_clk_div u_div (
        .sys_clk_i            (sys_clk_i),
        .rstn_i               (rstn_i),
        .ce_i                 (ce_i),
        .restart_i            (trig_fall),
        .clock_ratio_select_i (pins_sync.clock_ratio_select),
        .tick_o               (div_tick)
    );

    // Completing tick of the conversion
    assign last_tick = div_tick & (tick_cnt == SAMPLE_HOLD_TRIGGER_N_TICKS - TICK_CNT_ONE);

    // Conversion sequencer
    always_comb begin
        next_state    = state;
        next_tick_cnt = tick_cnt;
        next_result   = result;
        next_busy     = busy_o;
        next_hold     = hold_mode_o;
        unique case (state)
            ST_SAMPLE: begin
                // Fall is seen two edges after the pin; busy and hold rise on the next
                if (trig_fall) begin
                    next_state    = ST_CONVERT;
                    next_tick_cnt = TICK_CNT_ZERO;
                    next_busy     = 1'b1;
                    next_hold     = 1'b1;
                end
            end
            ST_CONVERT: begin
                // A falling strobe while busy starts no new conversion, but it still restarts the divider phase
                if (div_tick) begin
                    next_tick_cnt = tick_cnt + TICK_CNT_ONE;
                end
                if (last_tick) begin
                    next_state  = ST_SAMPLE;
                    next_busy   = 1'b0;
                    next_hold   = 1'b0;
                    next_result = sar_result_i;
                end
            end
        endcase
    end

    // Result and busy change on one edge, so a read after busy low sees the new word
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            state       <= ST_SAMPLE;
            tick_cnt    <= TICK_CNT_ZERO;
            result      <= RESULT_RST;
            busy_o      <= 1'b0;
            hold_mode_o <= 1'b0;
        end else if (ce_i) begin
            state       <= next_state;
            tick_cnt    <= next_tick_cnt;
            result      <= next_result;
            busy_o      <= next_busy;
            hold_mode_o <= next_hold;
        end
    end

    // Channel capture; a rising strobe in either state picks the next channel
    always_comb begin
        next_channel = channel_select_o;
        if (trig_rise) begin
            next_channel = pins_sync.channel_address;
        end
    end

    // One enable per analog input, measured against the common input
    genvar gi;
    generate
        for (gi = 0; gi < CHAN_N; gi++) begin : g_chan
            assign next_chan_en[gi] = (next_channel == 2'(gi));
        end
    endgenerate

    // Select and one-hot enable load together so they never disagree
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            channel_select_o <= CHAN_RST;
            channel_enable_o <= CHAN_EN_RST;
        end else if (ce_i) begin
            channel_select_o <= next_channel;
            channel_enable_o <= next_chan_en;
        end
    end

    // Read path: width select is re-evaluated every cycle while reading
    always_comb begin
        reading  = ~pins_sync.cs_n & ~pins_sync.rd_n
                   & (state == ST_SAMPLE) & ~trig_fall;
        next_bus = bus_word(result, pins_sync.byte_sel, reading);
    end

    // Data follows the result even when undriven; only the enables gate the lines
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            result_bus_o    <= RESULT_RST;
            result_bus_oe_o <= OE_NONE;
        end else if (ce_i) begin
            result_bus_o    <= next_bus.data;
            result_bus_oe_o <= next_bus.oe;
        end
    end
endmodule // sap_adc_ctrl

// ==== src/sap_pkg.sv ====
// Purpose: Shared constants and types for the converter control and read-out block
// Assumes: One system clock; host pins arrive asynchronously
// Notes:   All field widths and counts used by more than one file live here
package sap_pkg;
    localparam int              RESULT_W      = 16;
    localparam int              BYTE_W        = 8;
    localparam int              CHAN_N        = 4;
    localparam int              DIV_W         = 3;
    localparam logic [4:0]      SAMPLE_HOLD_TRIGGER_N_TICKS    = 5'h12;
    localparam logic [4:0]      TICK_CNT_ZERO = 5'h00;
    localparam logic [4:0]      TICK_CNT_ONE  = 5'h01;
    localparam logic [DIV_W-1:0] DIV_ZERO     = 3'h0;
    localparam logic [DIV_W-1:0] DIV_ONE      = 3'h1;
    localparam logic [DIV_W-1:0] DIV_LIM_1    = 3'h0;
    localparam logic [DIV_W-1:0] DIV_LIM_2    = 3'h1;
    localparam logic [DIV_W-1:0] DIV_LIM_4    = 3'h3;
    localparam logic [DIV_W-1:0] DIV_LIM_8    = 3'h7;
    localparam logic [15:0]     OE_FULL       = 16'hffff;
    localparam logic [15:0]     OE_LOW_BYTE   = 16'h00ff;
    localparam logic [15:0]     OE_NONE       = 16'h0000;
    localparam logic [15:0]     RESULT_RST    = 16'h0000;
    localparam logic [7:0]      BYTE_ZERO     = 8'h00;
    localparam logic [1:0]      CHAN_RST      = 2'h0;
    localparam logic [CHAN_N-1:0] CHAN_EN_RST = 4'h1;

    // Host-side pins, all asynchronous to the system clock
    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       sample_hold_trigger_n;
        logic       byte_sel;
        logic [1:0] channel_address;
        logic [1:0] clock_ratio_select;
    } sap_pins_t;

    localparam sap_pins_t PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, sample_hold_trigger_n: 1'b1,
                                        byte_sel: 1'b0, channel_address: 2'h0, clock_ratio_select: 2'h0};

    // Three-state data bus: value and per-line enable
    typedef struct packed {
        logic [15:0] data;
        logic [15:0] oe;
    } sap_bus_t;

    typedef enum logic {ST_SAMPLE, ST_CONVERT} sap_state_t;
endpackage

// ==== src/sap_clk_div.sv ====
// Purpose: Divides the converter clock by 1, 2, 4 or 8 into a one-cycle tick
// Assumes: Ratio input already synchronised
// Notes:   Restart realigns the phase to the start of a conversion
module sap_clk_div
    import sap_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    input  wire logic       ce_i,
    input  wire logic       restart_i,
    input  wire logic [1:0] clock_ratio_select_i,
    output logic            tick_o
);
    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] next_count;
    logic             next_tick;
    logic [DIV_W-1:0] limit;

    always_comb begin
        unique case (clock_ratio_select_i)
            2'h0: limit = DIV_LIM_1;
            2'h1: limit = DIV_LIM_2;
            2'h2: limit = DIV_LIM_4;
            2'h3: limit = DIV_LIM_8;
        endcase
        next_tick = 1'b0;
        if (restart_i) begin
            // Restart counts as the first ratio cycle, so tick k lands k ratios later
            if (limit == DIV_LIM_1) begin
                next_count = DIV_ZERO;
                next_tick  = 1'b1;
            end else begin
                next_count = DIV_ONE;
            end
        end else if (count >= limit) begin
            next_count = DIV_ZERO;
            next_tick  = 1'b1;
        end else begin
            next_count = count + DIV_ONE;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            count  <= DIV_ZERO;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            count  <= next_count;
            tick_o <= next_tick;
        end
    end
endmodule // sap_clk_div

// ==== test/sap_adc_ctrl_monitor.sv ====
// Purpose: Port checker for the converter control block
// Assumes: ce_i high; sar word steady through each conversion
// Notes:   Bound to every sap_adc_ctrl instance
module sap_adc_ctrl_monitor
    import sap_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rstn_i,
    input  wire sap_pins_t   pins_i,
    input  wire logic [15:0] sar_result_i,
    input  wire logic        busy_o,
    input  wire logic        hold_mode_o,
    input  wire logic [1:0]  channel_select_o,
    input  wire logic [3:0]  channel_enable_o,
    input  wire logic [15:0] result_bus_o,
    input  wire logic [15:0] result_bus_oe_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0]  busy_len;
    logic [15:0] res;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    // Cycles busy has stood high, and the word the read-out should show
    always_ff @(posedge sys_clk_i) begin
        busy_len <= (rstn_i && busy_o) ? busy_len + 8'h01 : 8'h00;
        res      <= !rstn_i ? RESULT_RST : (busy_o ? sar_result_i : res);
    end
    sequence sample_hold_trigger_n_start;
        $fell(pins_i.sample_hold_trigger_n) && !busy_o;
    endsequence
    sequence read_idle;
        (pins_i.cs_n || pins_i.rd_n) [*4];
    endsequence
    hold_start_a: assert property (sample_hold_trigger_n_start |-> ##3 hold_mode_o && busy_o) else $error("hold late");
    busy_hold_a: assert property (hold_mode_o == busy_o) else $error("hold and busy differ");
    busy_len_a: assert property ($fell(busy_o) |-> busy_len == (8'h12 << pins_i.clock_ratio_select))
        else $error("busy length wrong");
    bus_release_a: assert property (busy_o && $past(busy_o) |-> result_bus_oe_o == OE_NONE)
        else $error("bus driven in conversion");
    read_gate_a: assert property (read_idle |-> result_bus_oe_o == OE_NONE) else $error("bus driven");
    full_word_a: assert property (result_bus_oe_o == OE_FULL |-> result_bus_o == res)
        else $error("word wrong");
    upper_byte_a: assert property (result_bus_oe_o == OE_LOW_BYTE |-> result_bus_o == {BYTE_ZERO, res[15:8]})
        else $error("byte wrong");
    byte_mode_a: assert property (pins_i.byte_sel [*4] |-> result_bus_oe_o != OE_FULL)
        else $error("wide in byte mode");
    word_mode_a: assert property (!pins_i.byte_sel [*4] |-> result_bus_oe_o != OE_LOW_BYTE)
        else $error("narrow in word mode");
    chan_onehot_a: assert property (channel_enable_o == (4'h1 << channel_select_o)) else $error("mux");
    chan_latch_a: assert property ($rose(pins_i.sample_hold_trigger_n) |-> ##3
        channel_select_o == $past(pins_i.channel_address, 3)) else $error("address not latched");
endmodule // sap_adc_ctrl_monitor

bind sap_adc_ctrl sap_adc_ctrl_monitor mon (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .pins_i(pins_i),
    .sar_result_i(sar_result_i), .busy_o(busy_o), .hold_mode_o(hold_mode_o), .channel_select_o(channel_select_o),
    .channel_enable_o(channel_enable_o), .result_bus_o(result_bus_o), .result_bus_oe_o(result_bus_oe_o));

// ==== test/sap_host_model.sv ====
// Purpose: Host model driving the converter pins
// Assumes: Caller waits for busy low before reading
// Notes:   Pins change only just after a rising edge
module sap_host_model
    import sap_pkg::*;
(
    input  wire logic sys_clk_i,
    output sap_pins_t pins_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial pins_o = PINS_IDLE;
    // Strobe low for two cycles; chip select stays low through the conversion
    task automatic start(input logic [1:0] ch, input logic [1:0] ratio);
        @(posedge sys_clk_i);
        pins_o.channel_address       <= ch;
        pins_o.clock_ratio_select    <= ratio;
        pins_o.cs_n                  <= 1'b0;
        pins_o.sample_hold_trigger_n <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        pins_o.sample_hold_trigger_n <= 1'b1;
    endtask
    task automatic drive(input logic cs_n, input logic rd_n, input logic byte_sel);
        @(posedge sys_clk_i);
        pins_o.cs_n     <= cs_n;
        pins_o.rd_n     <= rd_n;
        pins_o.byte_sel <= byte_sel;
    endtask
endmodule // sap_host_model

// ==== test/sar_adc_parallel_host_interface_test.sv ====
// Purpose: Self-checking bench for the converter control block
// Assumes: ce_i held high
// Notes:   Outputs are sampled on falling edges
module sar_adc_parallel_host_interface_test;
    import sap_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [15:0] sar = 16'h0000;
    sap_pins_t   pins;
    logic        busy, hold;
    logic [1:0]  chs;
    logic [3:0]  che;
    logic [15:0] bus, oe;
    int          error_cnt = 0;
    int          num_checks = 0;
    const logic [15:0] vals [4] = '{16'h8001, 16'h4c3a, 16'hf0e1, 16'h0ff0};
    always #12.5 sys_clk_i = ~sys_clk_i;
    sap_adc_ctrl dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .pins_i(pins), .sar_result_i(sar),
        .busy_o(busy), .hold_mode_o(hold), .channel_select_o(chs), .channel_enable_o(che),
        .result_bus_o(bus), .result_bus_oe_o(oe));
    sap_host_model host (.sys_clk_i(sys_clk_i), .pins_o(pins));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Starts a conversion and returns how many cycles busy stood high
    task automatic convert(input logic [1:0] ch, input logic [1:0] r, input logic [15:0] v, output int n);
        int w;
        w = 0;
        n = 0;
        @(posedge sys_clk_i);
        sar <= v;
        host.start(ch, r);
        while (busy !== 1'b1 && w < 8) begin
            @(negedge sys_clk_i);
            w++;
        end
        while (busy === 1'b1 && n < 300) begin
            check(oe, OE_NONE);
            check(16'(hold), 16'h0001);
            @(negedge sys_clk_i);
            n++;
        end
    endtask
    task automatic ratio_sweep();
        int n;
        for (int r = 0; r < 4; r++) begin
            convert(2'(r), 2'(r), vals[r], n);
            check(16'(n), 16'h0012 << r);
            check(16'(hold), 16'h0000);
            check({12'h000, che}, 16'h0001 << r);
            check({14'h0000, chs}, 16'(r));
            host.drive(1'b0, 1'b0, 1'b0);
            repeat (5) @(negedge sys_clk_i);
            check(oe, OE_FULL);
            check(bus, vals[r]);
            host.drive(1'b1, 1'b1, 1'b0);
            repeat (5) @(negedge sys_clk_i);
            check(oe, OE_NONE);
        end
    endtask
    // Read held low through a conversion, then width select toggled under it
    task automatic read_through();
        int n;
        host.drive(1'b0, 1'b0, 1'b0);
        convert(2'h3, 2'h0, 16'h5ac3, n);
        repeat (5) @(negedge sys_clk_i);
        check(oe, OE_FULL);
        check(bus, 16'h5ac3);
        host.drive(1'b0, 1'b0, 1'b1);
        repeat (5) @(negedge sys_clk_i);
        check(oe, OE_LOW_BYTE);
        check(bus, 16'h005a);
        host.drive(1'b0, 1'b0, 1'b0);
        repeat (5) @(negedge sys_clk_i);
        check(oe, OE_FULL);
        check(bus, 16'h5ac3);
    endtask
    task automatic half_select();
        host.drive(1'b1, 1'b0, 1'b0);
        repeat (5) @(negedge sys_clk_i);
        check(oe, OE_NONE);
        host.drive(1'b0, 1'b1, 1'b0);
        repeat (5) @(negedge sys_clk_i);
        check(oe, OE_NONE);
        host.drive(1'b1, 1'b1, 1'b0);
    endtask
    initial begin
        repeat (12) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        ratio_sweep();
        read_through();
        half_select();
        repeat (4) @(posedge sys_clk_i);
        results();
    end
    initial begin
        #100us;
        error_cnt++;
        results();
    end
endmodule // sar_adc_parallel_host_interface_test
